// ### ltt_timer.sv
// top: timebase counters, input capture, register file and interrupt logic
`timescale 1ns/1ps
module ltt_timer
  import ltt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic capture_input_pin,
  input wire logic halt_mode,
  output logic irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic step;
  logic pin_edge;

  logic [7:0] counter1_q;
  logic period_half_q;
  logic [7:0] counter2_q;
  logic [7:0] reload_value_bits_q;
  logic [7:0] captured_value_bits_q;

  logic counter2_overflow_irq_enable_q;
  logic counter2_overflow_flag_q;
  logic capture_irq_enable_q;
  logic capture_flag_q;
  logic timebase_period_select_q;
  logic timebase1_irq_enable_q;
  logic timebase1_overflow_flag_q;

  logic [LTT_IRQ_NUM-1:0] irq_status_q;
  logic [LTT_IRQ_NUM-1:0] irq_enable_q;
  logic [LTT_IRQ_NUM-1:0] irq_event;

  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic sel_tb2;
  logic sel_reload;
  logic sel_live;
  logic sel_tb1;
  logic sel_cap;
  logic sel_irq_status;
  logic sel_irq_clear;
  logic sel_irq_enable;

  // one select per mapped byte; anything else reads zero
  always_comb begin
    sel_tb2 = 1'b0;
    sel_reload = 1'b0;
    sel_live = 1'b0;
    sel_tb1 = 1'b0;
    sel_cap = 1'b0;
    sel_irq_status = 1'b0;
    sel_irq_clear = 1'b0;
    sel_irq_enable = 1'b0;
    if (reg_addr == LTT_OFS_TB2_CTRL_STATUS) begin
      sel_tb2 = 1'b1;
    end else if (reg_addr == LTT_OFS_C2_RELOAD) begin
      sel_reload = 1'b1;
    end else if (reg_addr == LTT_OFS_C2_LIVE) begin
      sel_live = 1'b1;
    end else if (reg_addr == LTT_OFS_TB1_CAP_CTRL_STATUS) begin
      sel_tb1 = 1'b1;
    end else if (reg_addr == LTT_OFS_CAPTURED) begin
      sel_cap = 1'b1;
    end else if (reg_addr == LTT_OFS_IRQ_STATUS) begin
      sel_irq_status = 1'b1;
    end else if (reg_addr == LTT_OFS_IRQ_CLEAR) begin
      sel_irq_clear = 1'b1;
    end else if (reg_addr == LTT_OFS_IRQ_ENABLE) begin
      sel_irq_enable = 1'b1;
    end
  end

  // read strobes that carry a clearing side effect
  logic rd_tb2;
  logic rd_tb1;
  logic rd_cap;
  assign rd_tb2 = reg_rd && sel_tb2;
  assign rd_tb1 = reg_rd && sel_tb1;
  assign rd_cap = reg_rd && sel_cap;

  // ---------------------------------------------------------------
  // shared step source and capture edge
  // ---------------------------------------------------------------
  ltt_prescale u_prescale (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .halt_mode(halt_mode),
    .step(step)
  );

  ltt_edge_sync u_edge (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(capture_input_pin),
    .edge_seen(pin_edge)
  );

  // ---------------------------------------------------------------
  // counter 1: free-running timebase
  // ---------------------------------------------------------------
  logic c1_wrap;
  logic tb1_event;
  assign c1_wrap = step && (counter1_q == LTT_C1_LAST);
  // long period counts two wraps per event, so 16000 instead of 8000
  assign tb1_event = c1_wrap && (!timebase_period_select_q || period_half_q);

  // counter 1 from zero, one step per prescaler pulse; step is dead in halt
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      counter1_q <= LTT_RST_BYTE;
    end else if (c1_wrap) begin
      counter1_q <= LTT_RST_BYTE;
    end else if (step) begin
      counter1_q <= counter1_q + 8'h01;
    end
  end

  // half-period marker for the doubled timebase
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      period_half_q <= LTT_RST_BIT;
    end else if (!timebase_period_select_q) begin
      period_half_q <= LTT_RST_BIT; // short period: keep aligned for a later switch
    end else if (c1_wrap) begin
      period_half_q <= !period_half_q;
    end
  end

  // ---------------------------------------------------------------
  // counter 2: auto-reload timebase
  // ---------------------------------------------------------------
  logic tb2_event;
  assign tb2_event = step && (counter2_q == LTT_C2_LAST);

  // reload register is read at the wrap, so a new value waits for the next one
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      counter2_q <= LTT_RST_BYTE;
    end else if (tb2_event) begin
      counter2_q <= reload_value_bits_q;
    end else if (step) begin
      counter2_q <= counter2_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // input capture
  // ---------------------------------------------------------------
  logic cap_event;
  // flag still set inhibits the capture, so the first value is kept
  assign cap_event = pin_edge && !capture_flag_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      captured_value_bits_q <= LTT_RST_BYTE;
    end else if (cap_event) begin
      captured_value_bits_q <= counter1_q;
    end
  end

  // ---------------------------------------------------------------
  // software control bits
  // ---------------------------------------------------------------
  // enables and period select; reserved and flag bits of the write are dropped
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      counter2_overflow_irq_enable_q <= LTT_RST_BIT;
      capture_irq_enable_q <= LTT_RST_BIT;
      timebase_period_select_q <= LTT_RST_BIT;
      timebase1_irq_enable_q <= LTT_RST_BIT;
    end else if (reg_wr && sel_tb2) begin
      counter2_overflow_irq_enable_q <= reg_wdata[LTT_BIT_C2_OVF_IE];
    end else if (reg_wr && sel_tb1) begin
      capture_irq_enable_q <= reg_wdata[LTT_BIT_CAP_IE];
      timebase_period_select_q <= reg_wdata[LTT_BIT_PERIOD_SEL];
      timebase1_irq_enable_q <= reg_wdata[LTT_BIT_TB1_IE];
    end
  end

  // reload value; writes to the live count address are ignored
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reload_value_bits_q <= LTT_RST_BYTE;
    end else if (reg_wr && sel_reload) begin
      reload_value_bits_q <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // read-to-clear flags; hardware set beats the clearing read
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      counter2_overflow_flag_q <= LTT_RST_BIT;
    end else if (tb2_event) begin
      counter2_overflow_flag_q <= 1'b1;
    end else if (rd_tb2) begin
      counter2_overflow_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timebase1_overflow_flag_q <= LTT_RST_BIT;
    end else if (tb1_event) begin
      timebase1_overflow_flag_q <= 1'b1;
    end else if (rd_tb1) begin
      timebase1_overflow_flag_q <= 1'b0;
    end
  end

  // reset to zero here, though software still settles it with one read
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      capture_flag_q <= LTT_RST_BIT;
    end else if (cap_event) begin
      capture_flag_q <= 1'b1;
    end else if (rd_cap) begin
      capture_flag_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, clear and enable
  // ---------------------------------------------------------------
  // an event only requests when its own enable bit is set
  assign irq_event[LTT_IRQ_TB1] = tb1_event && timebase1_irq_enable_q;
  assign irq_event[LTT_IRQ_TB2] = tb2_event && counter2_overflow_irq_enable_q;
  assign irq_event[LTT_IRQ_CAP] = cap_event && capture_irq_enable_q;

  // sticky bits, write-one-to-clear; a new event in the clear cycle survives
  genvar gi;
  generate
    for (gi = 0; gi < LTT_IRQ_NUM; gi = gi + 1) begin : g_irq
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          irq_status_q[gi] <= LTT_RST_BIT;
        end else if (irq_event[gi]) begin
          irq_status_q[gi] <= 1'b1;
        end else if (reg_wr && sel_irq_clear && reg_wdata[gi]) begin
          irq_status_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_enable_q <= LTT_RST_IRQ;
    end else if (reg_wr && sel_irq_enable) begin
      irq_enable_q <= reg_wdata[LTT_IRQ_NUM-1:0];
    end
  end

  // level output, held while any enabled sticky bit stays set
  assign irq = |(irq_status_q & irq_enable_q);

  // ---------------------------------------------------------------
  // read path: data stand in the cycle after the strobe only
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = LTT_RST_BYTE;
    if (sel_tb2) begin
      rdata_d[LTT_BIT_C2_OVF_IE] = counter2_overflow_irq_enable_q;
      rdata_d[LTT_BIT_C2_OVF_FLAG] = counter2_overflow_flag_q;
    end else if (sel_reload) begin
      rdata_d = reload_value_bits_q;
    end else if (sel_live) begin
      rdata_d = counter2_q;
    end else if (sel_tb1) begin
      rdata_d[LTT_BIT_CAP_IE] = capture_irq_enable_q;
      rdata_d[LTT_BIT_CAP_FLAG] = capture_flag_q;
      rdata_d[LTT_BIT_PERIOD_SEL] = timebase_period_select_q;
      rdata_d[LTT_BIT_TB1_IE] = timebase1_irq_enable_q;
      rdata_d[LTT_BIT_TB1_OVF_FLAG] = timebase1_overflow_flag_q;
    end else if (sel_cap) begin
      rdata_d = captured_value_bits_q;
    end else if (sel_irq_status) begin
      rdata_d[LTT_IRQ_NUM-1:0] = irq_status_q;
    end else if (sel_irq_enable) begin
      rdata_d[LTT_IRQ_NUM-1:0] = irq_enable_q;
    end
  end

  // returns to zero outside the answer cycle so stale data never linger
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= LTT_RST_BYTE;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= LTT_RST_BYTE;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : ltt_timer

// ### ltt_pkg.sv
// package: register map, field positions, reset values and timing counts of the timebase/capture timer
package ltt_pkg;

  // register byte offsets
  localparam logic [7:0] LTT_OFS_TB2_CTRL_STATUS = 8'h08;
  localparam logic [7:0] LTT_OFS_C2_RELOAD = 8'h09;
  localparam logic [7:0] LTT_OFS_C2_LIVE = 8'h0A;
  localparam logic [7:0] LTT_OFS_TB1_CAP_CTRL_STATUS = 8'h0B;
  localparam logic [7:0] LTT_OFS_CAPTURED = 8'h0C;
  localparam logic [7:0] LTT_OFS_IRQ_STATUS = 8'h0D;
  localparam logic [7:0] LTT_OFS_IRQ_CLEAR = 8'h0E;
  localparam logic [7:0] LTT_OFS_IRQ_ENABLE = 8'h0F;

  // timebase2_ctrl_status fields
  localparam int LTT_BIT_C2_OVF_FLAG = 0;
  localparam int LTT_BIT_C2_OVF_IE = 1;

  // timebase1_capture_ctrl_status fields
  localparam int LTT_BIT_TB1_OVF_FLAG = 3;
  localparam int LTT_BIT_TB1_IE = 4;
  localparam int LTT_BIT_PERIOD_SEL = 5;
  localparam int LTT_BIT_CAP_FLAG = 6;
  localparam int LTT_BIT_CAP_IE = 7;

  // interrupt status / clear / enable layout
  localparam int LTT_IRQ_TB1 = 0;
  localparam int LTT_IRQ_TB2 = 1;
  localparam int LTT_IRQ_CAP = 2;
  localparam int LTT_IRQ_NUM = 3;

  // reset values
  localparam logic [7:0] LTT_RST_BYTE = 8'h00;
  localparam logic LTT_RST_BIT = 1'b0;
  localparam logic [LTT_IRQ_NUM-1:0] LTT_RST_IRQ = 3'h0;

  // timing: counters step once per this many oscillator cycles
  localparam int LTT_OSC_DIV = 32;
  localparam int LTT_DIV_W = $clog2(LTT_OSC_DIV);
  localparam logic [LTT_DIV_W-1:0] LTT_DIV_LAST = LTT_DIV_W'(LTT_OSC_DIV - 1);
  // counter 1 wraps F9h -> 00h: 250 steps of 32 = 8000 oscillator periods
  localparam logic [7:0] LTT_C1_LAST = 8'hF9;
  // counter 2 overflows past FFh
  localparam logic [7:0] LTT_C2_LAST = 8'hFF;

endpackage : ltt_pkg

// ### ltt_prescale.sv
// prescaler: one-cycle step pulse every 32 oscillator cycles, frozen in halt
`timescale 1ns/1ps
module ltt_prescale
  import ltt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic halt_mode,
  output logic step
);

  logic [LTT_DIV_W-1:0] div_q;

  // free count of oscillator cycles; holds its place while halted
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_q <= '0;
    end else if (!halt_mode) begin
      div_q <= div_q + 1'b1;
    end
  end

  // step only on the last cycle of each group, never while halted
  assign step = !halt_mode && (div_q == LTT_DIV_LAST);

endmodule : ltt_prescale

// ### ltt_edge_sync.sv
// capture pin synchroniser and both-edge detector
`timescale 1ns/1ps
module ltt_edge_sync
  import ltt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic edge_seen
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // two flops before any logic; only sync_q reads meta_q
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_q <= LTT_RST_BIT;
      sync_q <= LTT_RST_BIT;
      last_q <= LTT_RST_BIT;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // rising or falling edge of the synchronised level
  // note: a pin level that differs from reset low gives one edge after reset
  assign edge_seen = sync_q ^ last_q;

endmodule : ltt_edge_sync

// ### ltt_timer_assertions.sv
// checker: register port, reload, halt and interrupt relations of the timebase/capture timer
`timescale 1ns/1ps
module ltt_timer_chk
  import ltt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic capture_input_pin,
  input wire logic halt_mode,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic rd_q;
  logic [7:0] ra_q;
  // remember which offset the answer on the read port belongs to
  always_ff @(posedge ref_clk) begin
    rd_q <= reg_rd;
    ra_q <= reg_addr;
  end
  rdata_idle_a: assert property (!rd_q |-> reg_rdata == 8'h00)
    else $error("read data not zero outside an answer");
  unmapped_zero_a: assert property (rd_q && (ra_q < LTT_OFS_TB2_CTRL_STATUS || ra_q > LTT_OFS_IRQ_ENABLE)
    |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
  tb2_reserved_a: assert property (rd_q && ra_q == LTT_OFS_TB2_CTRL_STATUS |-> reg_rdata[7:2] == 6'h00)
    else $error("reserved bits of 08 not zero");
  tb1_reserved_a: assert property (rd_q && ra_q == LTT_OFS_TB1_CAP_CTRL_STATUS |-> reg_rdata[2:0] == 3'h0)
    else $error("reserved bits of 0B not zero");
  reload_keep_a: assert property (reg_wr && reg_addr == LTT_OFS_C2_RELOAD ##1 !reg_wr ##1
    reg_rd && reg_addr == LTT_OFS_C2_RELOAD |=> reg_rdata == $past(reg_wdata, 3)) else $error("reload lost");
  live_frozen_a: assert property (halt_mode[*3] ##0 (reg_rd && reg_addr == LTT_OFS_C2_LIVE) ##1 halt_mode
    ##1 (halt_mode && reg_rd && reg_addr == LTT_OFS_C2_LIVE) |=> reg_rdata == $past(reg_rdata, 2))
    else $error("counter 2 moved in halt");
  irq_gate_a: assert property (reg_wr && reg_addr == LTT_OFS_IRQ_ENABLE && reg_wdata[2:0] == 3'h0 |=> !irq)
    else $error("irq high with all enables off");
  reset_quiet_a: assert property ($fell(sys_rst) |-> !irq && reg_rdata == 8'h00)
    else $error("outputs not quiet after reset");
  // main scenarios reached
  cover property (reg_rd && reg_addr == LTT_OFS_CAPTURED);
  cover property ($rose(irq));
  cover property (reg_wr && reg_addr == LTT_OFS_TB1_CAP_CTRL_STATUS);
endmodule : ltt_timer_chk

bind ltt_timer ltt_timer_chk ltt_timer_chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .capture_input_pin(capture_input_pin), .halt_mode(halt_mode), .irq(irq));

// ### ltt_cap_src.sv
// capture pin source: an external level that flips on request, off the clock edge
`timescale 1ns/1ps
module ltt_cap_src (
  input wire logic ref_clk,
  input wire logic flip,
  output logic pin
);
  // driven push-pull, so it keeps its level; 3 ns skew makes it asynchronous to the timer
  initial pin = 1'b0;
  always @(posedge ref_clk) if (flip) pin <= #3 ~pin;
endmodule : ltt_cap_src

// ### lite_timebase_capture_timer_tb.sv
// testbench: registers, timebases, reload, halt and capture against a bench model
`timescale 1ns/1ps
module lite_timebase_capture_timer_tb;
  import ltt_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic halt_mode = 1'b0;
  logic flip = 1'b0;
  logic pin;
  logic [7:0] reg_rdata;
  logic irq;
  logic [7:0] rv;
  logic [7:0] cap_a;
  logic [7:0] offs [7] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0F, 8'h05};
  integer seed = 32'h7688;
  integer miscompares = 0;
  integer compares = 0;
  integer cycles = 0;
  integer dv = 0;
  integer c1 = 0;
  integer c2 = 0;
  integer rl = 0;
  integer n;
  time t0;
  always #5 ref_clk = ~ref_clk;
  ltt_timer ltt_timer_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_input_pin(pin),
    .halt_mode(halt_mode), .irq(irq));
  ltt_cap_src ltt_cap_src_i (.ref_clk(ref_clk), .flip(flip), .pin(pin));
  // bench model of prescaler and both counters, plus the hang limit
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles > 95000) begin
      miscompares = miscompares + 1;
      conclude();
    end
    if (sys_rst) begin
      dv = 0;
      c1 = 0;
      c2 = 0;
    end else if (!halt_mode) begin
      dv = dv + 1;
      if (dv == 32) begin
        dv = 0;
        c1 = (c1 == 249) ? 0 : c1 + 1;
        c2 = (c2 == 255) ? rl : c2 + 1;
      end
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    if (a == LTT_OFS_C2_RELOAD) rl = d;
  endtask : wr
  // read and compare; the answer stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    check($sformatf("register %h", a), {24'h0, rv}, {24'h0, exp});
  endtask : rdc
  task automatic irq_is(input logic e);
    #1 check("irq", {31'h0, irq}, {31'h0, e});
  endtask : irq_is
  // change halt only mid-way through a prescaler period, so the model can't straddle a step
  task automatic hold(input logic h);
    // look after the model has moved, so halting always freezes the model at 16
    do begin
      @(posedge ref_clk);
      #1;
    end while (h && dv != 15);
    @(posedge ref_clk);
    halt_mode <= h;
    repeat (3) @(posedge ref_clk);
  endtask : hold
  task automatic wait_irq();
    // let a clear written at this edge settle before irq is looked at
    #1 n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge ref_clk);
      #1 n = n + 1;
    end
  endtask : wait_irq
  task automatic pin_flip();
    @(posedge ref_clk);
    flip <= 1'b1;
    @(posedge ref_clk);
    flip <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask : pin_flip
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc(LTT_OFS_CAPTURED, 8'h00);
    foreach (offs[i]) rdc(offs[i], 8'h00);
    $display("test reset values done");
    // reload kept below 80h so overflows stay over 4000 cycles apart
    rv = 8'($random(seed)) & 8'h7F;
    wr(LTT_OFS_C2_RELOAD, rv);
    rdc(LTT_OFS_C2_RELOAD, rl[7:0]);
    wr(LTT_OFS_TB2_CTRL_STATUS, 8'h03); // reserved bits kept zero
    rdc(LTT_OFS_TB2_CTRL_STATUS, 8'h02);
    hold(1'b1);
    rdc(LTT_OFS_C2_LIVE, c2[7:0]);
    rdc(LTT_OFS_C2_LIVE, c2[7:0]);
    wr(LTT_OFS_C2_LIVE, ~c2[7:0]);
    rdc(LTT_OFS_C2_LIVE, c2[7:0]);
    hold(1'b0);
    $display("test halt and live count done");
    wr(LTT_OFS_IRQ_ENABLE, 8'h02);
    wait_irq();
    rdc(LTT_OFS_IRQ_STATUS, 8'h02);
    rdc(LTT_OFS_TB2_CTRL_STATUS, 8'h03);
    rdc(LTT_OFS_TB2_CTRL_STATUS, 8'h02);
    wr(LTT_OFS_IRQ_CLEAR, 8'h02);
    irq_is(1'b0);
    hold(1'b1);
    rdc(LTT_OFS_C2_LIVE, c2[7:0]);
    hold(1'b0);
    $display("test counter 2 overflow done");
    wr(LTT_OFS_IRQ_ENABLE, 8'h01);
    for (int s = 1; s >= 0; s--) begin
      wr(LTT_OFS_TB1_CAP_CTRL_STATUS, s ? 8'h30 : 8'h10);
      wait_irq();
      t0 = $time;
      wr(LTT_OFS_IRQ_CLEAR, 8'h01);
      wait_irq();
      check("timebase period", 32'(($time - t0) / 10), 32'(8000 * (s + 1)));
      wr(LTT_OFS_IRQ_CLEAR, 8'h01);
    end
    rdc(LTT_OFS_TB1_CAP_CTRL_STATUS, 8'h18);
    rdc(LTT_OFS_TB1_CAP_CTRL_STATUS, 8'h10);
    $display("test timebase 1 done");
    wr(LTT_OFS_IRQ_ENABLE, 8'h04);
    wr(LTT_OFS_TB1_CAP_CTRL_STATUS, 8'h80);
    hold(1'b1);
    pin_flip();
    irq_is(1'b1);
    rdc(LTT_OFS_TB1_CAP_CTRL_STATUS, 8'hC0);
    rdc(LTT_OFS_CAPTURED, c1[7:0]);
    rdc(LTT_OFS_TB1_CAP_CTRL_STATUS, 8'h80);
    hold(1'b0);
    repeat (100) @(posedge ref_clk);
    hold(1'b1);
    cap_a = c1[7:0];
    pin_flip();
    hold(1'b0);
    repeat (100) @(posedge ref_clk);
    hold(1'b1);
    pin_flip();
    rdc(LTT_OFS_CAPTURED, cap_a);
    wr(LTT_OFS_IRQ_CLEAR, 8'h04);
    wr(LTT_OFS_IRQ_ENABLE, 8'h00);
    irq_is(1'b0);
    $display("test capture done");
    conclude();
  end
endmodule : lite_timebase_capture_timer_tb
